//--- src/dcm_pkg.sv
// Purpose: shared constants and types of the cache block maintenance unit
// Assumes: 32-bit instruction words, bit 0 is the most significant bit
// Notes:   blocks are four 32-bit words
package dcm_pkg;
   // word and field layout (bit 0 of the printed layout is bit 31 here)
   localparam int XLEN    = 32;
   localparam int PRI_LSB = 26;
   localparam int PRI_W   = 6;
   localparam int RA_LSB  = 16;
   localparam int REG_W   = 5;
   localparam int XO_LSB  = 1;
   localparam int XO_W    = 10;

   // opcodes
   localparam logic [5:0] PRI_CACHE = 6'h1F;
   localparam logic [9:0] XO_FLUSH  = 10'h056;
   localparam logic [9:0] XO_INVAL  = 10'h1D6;
   localparam logic [9:0] XO_STORE  = 10'h036;

   // block geometry
   localparam int BLK_WORDS = 4;
   localparam int WIDX_W    = 2;
   localparam int BLK_LSB   = 4;
   localparam int RDCNT_W   = 3;

   typedef enum logic [1:0] {
      OP_NONE  = 2'h0,
      OP_FLUSH = 2'h1,
      OP_INVAL = 2'h2,
      OP_STORE = 2'h3
   } dcm_op_e;

   typedef enum logic [2:0] {
      S_IDLE   = 3'h0,
      S_XLATE  = 3'h1,
      S_LOOKUP = 3'h3,
      S_READ   = 3'h2,
      S_WRITE  = 3'h6,
      S_INVAL  = 3'h7,
      S_DONE   = 3'h5
   } dcm_state_e;

   typedef struct packed {
      logic [XLEN-1:0] instr;
      logic [XLEN-1:0] baseVal;
      logic [XLEN-1:0] indexVal;
      logic            privileged;
   } dcm_issue_s;

   typedef struct packed {
      dcm_op_e         op;
      logic [XLEN-1:0] ea;
      logic            privileged;
   } dcm_cmd_s;

   typedef struct packed {
      logic illegal;
      logic privFault;
      logic noop;
      logic protFault;
      logic wroteBack;
      logic invalidated;
   } dcm_result_s;
endpackage : dcm_pkg

//--- src/dcm_line_buf.sv
// Purpose: one-block staging memory between cache read and memory write
// Assumes: one write and one read port, read data registered
// Notes:   read data follows the read index by one clock
`timescale 1ns/100ps
module dcm_line_buf (
   // clock and reset
   input  wire logic                          clock,
   input  wire logic                          reset,
   // write port
   input  wire logic                          wrEn,
   input  wire logic [dcm_pkg::WIDX_W-1:0]    wrIdx,
   input  wire logic [dcm_pkg::XLEN-1:0]      wrData,
   // read port
   input  wire logic [dcm_pkg::WIDX_W-1:0]    rdIdx,
   output logic      [dcm_pkg::XLEN-1:0]      rdData
);
   logic [dcm_pkg::XLEN-1:0] mem [dcm_pkg::BLK_WORDS];

   always_ff @(posedge clock)
   begin
      if (wrEn)
      begin
         mem[wrIdx] <= wrData;
      end
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         rdData <= '0;
      end
      else
      begin
         rdData <= mem[rdIdx];
      end
   end
endmodule : dcm_line_buf

//--- src/dcm_decode.sv
// Purpose: opcode decode and effective address capture
// Assumes: operands arrive with the instruction word
// Notes:   fields 6-10 and bit 31 are ignored
`timescale 1ns/100ps
module dcm_decode (
   // clock and reset
   input  wire logic         clock,
   input  wire logic         reset,
   // issue capture
   input  wire logic         load,
   input  dcm_pkg::dcm_issue_s issue,
   // decoded command
   output dcm_pkg::dcm_cmd_s cmd
);
   // RQ1 RQ7 RQ12 base field zero
   function automatic logic [31:0] formEa(input logic [4:0] field,
                                          input logic [31:0] baseVal,
                                          input logic [31:0] indexVal);
      formEa = (field == 5'h00) ? indexVal : baseVal + indexVal;
   endfunction : formEa

   // RQ5 RQ11 RQ15 opcode decode
   function automatic dcm_pkg::dcm_op_e decodeOp(input logic [31:0] w);
      logic [5:0] pri;
      logic [9:0] xo;
      pri = w[dcm_pkg::PRI_LSB +: dcm_pkg::PRI_W];
      xo  = w[dcm_pkg::XO_LSB +: dcm_pkg::XO_W];
      decodeOp = dcm_pkg::OP_NONE;
      if (pri == dcm_pkg::PRI_CACHE)
      begin
         case (xo)
            dcm_pkg::XO_FLUSH: decodeOp = dcm_pkg::OP_FLUSH;
            dcm_pkg::XO_INVAL: decodeOp = dcm_pkg::OP_INVAL;
            dcm_pkg::XO_STORE: decodeOp = dcm_pkg::OP_STORE;
            default:           decodeOp = dcm_pkg::OP_NONE;
         endcase
      end
   endfunction : decodeOp

   logic [4:0]  baseField;
   logic [5:0]  priField;
   logic [9:0]  xoField;
   logic [31:0] issueSum;
   logic        baseZero;

   assign baseField = issue.instr[dcm_pkg::RA_LSB +: dcm_pkg::REG_W];
   assign priField  = issue.instr[dcm_pkg::PRI_LSB +: dcm_pkg::PRI_W];
   assign xoField   = issue.instr[dcm_pkg::XO_LSB +: dcm_pkg::XO_W];
   assign issueSum  = issue.baseVal + issue.indexVal;
   assign baseZero  = baseField == 5'h00;

   // RQ1 RQ5 capture command
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         cmd <= '0;
      end
      else if (load)
      begin
         cmd.op         <= decodeOp(issue.instr);
         cmd.ea         <= formEa(baseField, issue.baseVal, issue.indexVal);
         cmd.privileged <= issue.privileged;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   a_flush_ea_form: assert property ( // RQ1
      load && decodeOp(issue.instr) == dcm_pkg::OP_FLUSH |=>
      cmd.ea == ($past(baseZero) ? $past(issue.indexVal) : $past(issueSum)))
      else $error("flush address wrong");
   a_inval_ea_form: assert property ( // RQ7
      load && decodeOp(issue.instr) == dcm_pkg::OP_INVAL |=>
      cmd.ea == ($past(baseZero) ? $past(issue.indexVal) : $past(issueSum)))
      else $error("invalidate address wrong");
   a_store_ea_form: assert property ( // RQ12
      load && decodeOp(issue.instr) == dcm_pkg::OP_STORE |=>
      cmd.ea == ($past(baseZero) ? $past(issue.indexVal) : $past(issueSum)))
      else $error("store address wrong");
   a_dec_flush_op: assert property ( // RQ5
      load && priField == 6'h1F && xoField == 10'h056 |=>
      cmd.op == dcm_pkg::OP_FLUSH)
      else $error("flush not decoded");
   a_dec_inval_op: assert property ( // RQ11
      load && priField == 6'h1F && xoField == 10'h1D6 |=>
      cmd.op == dcm_pkg::OP_INVAL)
      else $error("invalidate not decoded");
   a_dec_store_op: assert property ( // RQ15
      load && priField == 6'h1F && xoField == 10'h036 |=>
      cmd.op == dcm_pkg::OP_STORE)
      else $error("store not decoded");
endmodule : dcm_decode

//--- src/dcm_block_maint.sv
// Purpose: data cache block flush, invalidate and store sequencer
// Assumes: translation and cache directory answer in the asking cycle
// Notes:   cache word reads return one clock after the read enable
// Notes on behaviour
// RQ1: Flush address is base plus index, base taken as zero for field 0.
// RQ2: Flush writes a present modified block back to main memory.
// RQ3: Flush invalidates a present block after any write back.
// RQ4: Flush to a direct-store segment does nothing and completes.
// RQ5: Flush is opcode 31 with extended opcode 86, fields 6-10, 31 unused.
// RQ6: Flush never writes the fixed-point exception status register.
// RQ7: Invalidate address is base plus index, or index alone for field 0.
// RQ8: Invalidate drops a present block so later reads refetch it.
// RQ9: Invalidate is checked for protection as a store.
// RQ10: Invalidate is accepted only in privileged state, else faults.
// RQ11: Invalidate is opcode 31 with extended opcode 470.
// RQ12: Store address is base plus index, or index alone for field 0.
// RQ13: Store copies a present modified block to main memory.
// RQ14: Store is translated and checked for protection as a load.
// RQ15: Store is opcode 31 with extended opcode 54.
// RQ16: Flush and store write nothing when the block is absent or clean.
`timescale 1ns/100ps
module dcm_block_maint (
   // clock and reset
   input  wire logic                               clock,
   input  wire logic                               reset,
   // issue from the core
   input  wire logic                               issueValid,
   output logic                                    issueReady,
   input  dcm_pkg::dcm_issue_s                     issue,
   // completion to the core
   output logic                                    resultValid,
   output dcm_pkg::dcm_result_s                    result,
   output logic                                    xerWrite,
   // translation and protection
   output logic                                    xlateReq,
   output logic      [dcm_pkg::XLEN-1:0]           xlateEa,
   output logic                                    xlateAsStore,
   input  wire logic                               xlateDirect,
   input  wire logic                               xlateDenied,
   // cache directory and data
   output logic                                    cacheLookup,
   output logic      [dcm_pkg::XLEN-1:dcm_pkg::BLK_LSB] cacheAddr,
   input  wire logic                               cacheHit,
   input  wire logic                               cacheDirty,
   output logic                                    cacheRdEn,
   output logic      [dcm_pkg::WIDX_W-1:0]         cacheRdWord,
   input  wire logic [dcm_pkg::XLEN-1:0]           cacheRdData,
   output logic                                    cacheInval,
   // main memory write
   output logic                                    memValid,
   input  wire logic                               memReady,
   output logic      [dcm_pkg::XLEN-1:0]           memAddr,
   output logic      [dcm_pkg::XLEN-1:0]           memData,
   output logic                                    memLast
);
   dcm_pkg::dcm_state_e state;
   dcm_pkg::dcm_state_e next_state;
   dcm_pkg::dcm_cmd_s   cmd;

   logic [dcm_pkg::RDCNT_W-1:0] rdCnt;
   logic                        rdPend;
   logic [dcm_pkg::WIDX_W-1:0]  rdIdx;
   logic [dcm_pkg::WIDX_W-1:0]  wrCnt;
   logic                        primed;
   logic                        load;
   logic                        privFault;
   logic                        xlateStop;
   logic                        needWb;
   logic                        needInval;
   logic                        memFire;
   logic                        isFlush;
   logic                        isInval;
   logic                        isStore;

   dcm_decode u_decode (
      .clock (clock),
      .reset (reset),
      .load  (load),
      .issue (issue),
      .cmd   (cmd)
   );

   dcm_line_buf u_line_buf (
      .clock  (clock),
      .reset  (reset),
      .wrEn   (rdPend),
      .wrIdx  (rdIdx),
      .wrData (cacheRdData),
      .rdIdx  (wrCnt),
      .rdData (memData)
   );

   assign isFlush     = cmd.op == dcm_pkg::OP_FLUSH;
   assign isInval     = cmd.op == dcm_pkg::OP_INVAL;
   assign isStore     = cmd.op == dcm_pkg::OP_STORE;
   assign issueReady  = state == dcm_pkg::S_IDLE;
   assign load        = issueValid && issueReady;
   assign resultValid = state == dcm_pkg::S_DONE;
   // RQ6 status register untouched
   assign xerWrite    = 1'b0;

   // translation request
   assign xlateReq = state == dcm_pkg::S_XLATE;
   assign xlateEa  = cmd.ea;
   // RQ9 RQ14 store class only for invalidate
   assign xlateAsStore = isInval;

   // RQ10 privilege check
   assign privFault = isInval && !cmd.privileged;
   // RQ4 direct-store and faults end the operation
   assign xlateStop = cmd.op == dcm_pkg::OP_NONE || privFault
                      || xlateDirect || xlateDenied;

   // RQ2 RQ13 RQ16 write back only present modified
   assign needWb    = (isFlush || isStore) && cacheHit && cacheDirty;
   // RQ3 RQ8 invalidate present block
   assign needInval = (isFlush || isInval) && cacheHit;

   // cache side
   assign cacheLookup = state == dcm_pkg::S_LOOKUP;
   assign cacheAddr   = cmd.ea[dcm_pkg::XLEN-1:dcm_pkg::BLK_LSB];
   assign cacheRdEn   = state == dcm_pkg::S_READ && !rdCnt[2];
   assign cacheRdWord = rdCnt[dcm_pkg::WIDX_W-1:0];
   assign cacheInval  = state == dcm_pkg::S_INVAL;

   // memory side
   assign memValid = state == dcm_pkg::S_WRITE && primed;
   assign memFire  = memValid && memReady;
   assign memLast  = wrCnt == 2'h3;
   assign memAddr  = {cmd.ea[dcm_pkg::XLEN-1:dcm_pkg::BLK_LSB], wrCnt, 2'h0};

   always_comb
   begin
      next_state = state;
      case (state)
         dcm_pkg::S_IDLE:
         begin
            if (issueValid)
            begin
               next_state = dcm_pkg::S_XLATE;
            end
         end
         dcm_pkg::S_XLATE:
         begin
            if (xlateStop)
            begin
               next_state = dcm_pkg::S_DONE;
            end
            else
            begin
               next_state = dcm_pkg::S_LOOKUP;
            end
         end
         dcm_pkg::S_LOOKUP:
         begin
            if (needWb)
            begin
               next_state = dcm_pkg::S_READ;
            end
            else if (needInval)
            begin
               next_state = dcm_pkg::S_INVAL;
            end
            else
            begin
               next_state = dcm_pkg::S_DONE;
            end
         end
         dcm_pkg::S_READ:
         begin
            if (rdCnt[2] && !rdPend)
            begin
               next_state = dcm_pkg::S_WRITE;
            end
         end
         dcm_pkg::S_WRITE:
         begin
            // RQ3 invalidate follows write back
            if (memFire && memLast)
            begin
               next_state = isFlush ? dcm_pkg::S_INVAL : dcm_pkg::S_DONE;
            end
         end
         dcm_pkg::S_INVAL: next_state = dcm_pkg::S_DONE;
         dcm_pkg::S_DONE:  next_state = dcm_pkg::S_IDLE;
         default:          next_state = dcm_pkg::S_IDLE;
      endcase
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         state <= dcm_pkg::S_IDLE;
      end
      else
      begin
         state <= next_state;
      end
   end

   // block read from the cache into the staging buffer
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         rdCnt  <= '0;
         rdPend <= 1'b0;
         rdIdx  <= '0;
      end
      else if (state != dcm_pkg::S_READ)
      begin
         rdCnt  <= '0;
         rdPend <= 1'b0;
      end
      else
      begin
         rdPend <= cacheRdEn;
         rdIdx  <= rdCnt[dcm_pkg::WIDX_W-1:0];
         if (cacheRdEn)
         begin
            rdCnt <= rdCnt + 3'h1;
         end
      end
   end

   // RQ2 RQ13 stream block to main memory
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         wrCnt  <= '0;
         primed <= 1'b0;
      end
      else if (state != dcm_pkg::S_WRITE)
      begin
         wrCnt  <= '0;
         primed <= 1'b0;
      end
      else if (memFire)
      begin
         wrCnt  <= wrCnt + 2'h1;
         primed <= 1'b0;
      end
      else
      begin
         primed <= 1'b1;
      end
   end

   // completion flags
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         result <= '0;
      end
      else if (load)
      begin
         result <= '0;
      end
      else if (state == dcm_pkg::S_XLATE)
      begin
         result.illegal <= cmd.op == dcm_pkg::OP_NONE;
         // RQ10 unprivileged invalidate faults
         result.privFault <= cmd.op != dcm_pkg::OP_NONE && privFault;
         // RQ4 direct-store segment is a no-op
         result.noop <= cmd.op != dcm_pkg::OP_NONE && !privFault
                        && xlateDirect;
         result.protFault <= cmd.op != dcm_pkg::OP_NONE && !privFault
                             && !xlateDirect && xlateDenied;
      end
      else if (memFire && memLast)
      begin
         result.wroteBack <= 1'b1;
      end
      else if (cacheInval)
      begin
         result.invalidated <= 1'b1;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   a_flush_wb_dirty: assert property ( // RQ2
      cacheLookup && isFlush && cacheHit && cacheDirty |->
      ##8 memValid && wrCnt == 2'h0)
      else $error("flush did not start write back");
   a_flush_inval_wb: assert property ( // RQ3
      memFire && memLast && isFlush |=> cacheInval ##1 resultValid)
      else $error("flush did not invalidate after write back");
   a_direct_noop: assert property ( // RQ4
      xlateReq && isFlush && xlateDirect |=>
      resultValid && result.noop && !cacheInval)
      else $error("direct-store flush not a no-op");
   a_xer_quiet: assert property ( // RQ6
      resultValid |-> !xerWrite)
      else $error("status register written");
   a_inval_hit: assert property ( // RQ8
      cacheLookup && isInval && cacheHit |=> cacheInval)
      else $error("invalidate hit not dropped");
   a_inval_as_store: assert property ( // RQ9
      xlateReq && isInval |-> xlateAsStore)
      else $error("invalidate not checked as store");
   a_priv_fault: assert property ( // RQ10
      xlateReq && isInval && !cmd.privileged |=>
      resultValid && result.privFault && !cacheLookup)
      else $error("unprivileged invalidate accepted");
   a_store_wb_dirty: assert property ( // RQ13
      cacheLookup && isStore && cacheHit && cacheDirty |->
      ##8 memValid && wrCnt == 2'h0)
      else $error("store did not start write back");
   a_store_as_load: assert property ( // RQ14
      xlateReq && isStore |-> !xlateAsStore)
      else $error("store not checked as load");
   a_no_clean_wb: assert property ( // RQ16
      cacheLookup && !isInval && !(cacheHit && cacheDirty) |=>
      !memValid [*6])
      else $error("write back of clean or absent block");

   c_flush_dirty: cover property (memFire && memLast && isFlush);
   c_store_dirty: cover property (memFire && memLast && isStore);
   c_inval_hit: cover property (cacheInval && isInval);
   c_direct_noop: cover property (resultValid && result.noop);
endmodule : dcm_block_maint

//--- tb/dcm_far_model.sv
// Purpose: far side model: translation, cache arrays and main memory
// Assumes: answers in the asking cycle, read data one clock later
// Notes:   records what the block asked for, counters cleared by clr
`timescale 1ns/100ps
module dcm_far_model (
   // clock and control
   input  wire logic          clock,
   input  wire logic          clr,
   input  wire logic          cfgDirect,
   input  wire logic          cfgDenied,
   input  wire logic          cfgHit,
   input  wire logic          cfgDirty,
   input  wire logic          cfgStall,
   // translation
   input  wire logic          xlateReq,
   input  wire logic [31:0]   xlateEa,
   input  wire logic          xlateAsStore,
   output logic               xlateDirect,
   output logic               xlateDenied,
   // cache
   input  wire logic          cacheLookup,
   input  wire logic [31:4]   cacheAddr,
   output logic               cacheHit,
   output logic               cacheDirty,
   input  wire logic          cacheRdEn,
   input  wire logic [1:0]    cacheRdWord,
   output logic      [31:0]   cacheRdData,
   input  wire logic          cacheInval,
   // memory
   input  wire logic          memValid,
   output logic               memReady,
   input  wire logic [31:0]   memAddr,
   input  wire logic [31:0]   memData,
   input  wire logic          memLast,
   // observations
   output logic      [31:0]   seenEa,
   output logic               seenAsStore,
   output int                 nXlate,
   output int                 nWrite,
   output int                 nBad,
   output int                 nInval
);
   logic tgl;
   logic badBeat;
   logic badAddr;

   function automatic logic [31:0] pat(input logic [31:0] a);
      return a ^ 32'h5A3C_0000;
   endfunction : pat

   // answers only inside the asking cycle, inverted otherwise
   assign xlateDirect = xlateReq ? cfgDirect : ~cfgDirect;
   assign xlateDenied = xlateReq ? cfgDenied : ~cfgDenied;
   assign cacheHit    = cacheLookup ? cfgHit : ~cfgHit;
   assign cacheDirty  = cacheLookup ? cfgDirty : ~cfgDirty;
   assign memReady    = ~cfgStall | tgl;
   assign badBeat = memValid && memReady &&
      (memAddr !== {cacheAddr, nWrite[1:0], 2'h0} ||
       memData !== pat(memAddr) || memLast !== (nWrite[1:0] == 2'h3));
   assign badAddr = (cacheLookup || cacheInval) &&
      cacheAddr !== seenEa[31:4];

   always @(posedge clock)
   begin
      if (clr)
      begin
         tgl <= 1'b0;
         cacheRdData <= 32'h0;
         nXlate <= 0;
         nWrite <= 0;
         nBad <= 0;
         nInval <= 0;
      end
      else
      begin
         tgl <= ~tgl;
         cacheRdData <= cacheRdEn ? pat({cacheAddr, cacheRdWord, 2'h0})
                                  : ~cacheRdData;
         if (xlateReq)
         begin
            nXlate <= nXlate + 1;
            seenEa <= xlateEa;
            seenAsStore <= xlateAsStore;
         end
         nInval <= nInval + (cacheInval ? 1 : 0);
         nWrite <= nWrite + ((memValid && memReady) ? 1 : 0);
         nBad <= nBad + (badBeat ? 1 : 0) + (badAddr ? 1 : 0);
      end
   end
endmodule : dcm_far_model

//--- tb/testbench.sv
// Purpose: self-checking bench of the cache block maintenance unit
// Assumes: one operation at a time, far side given by the model
// Notes:   random operations after six hand-picked corner cases
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
   begin \
      testsRun++; \
      if ((got) !== (exp)) \
      begin \
         errorCnt++; \
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); \
      end \
   end
module testbench;
   logic clock, reset, issueValid, issueReady, resultValid, xerWrite;
   logic xlateReq, xlateAsStore, xlateDirect, xlateDenied;
   logic cacheLookup, cacheHit, cacheDirty, cacheRdEn, cacheInval;
   logic memValid, memReady, memLast, clr, xerSeen, seenAsStore;
   logic cfgDirect, cfgDenied, cfgHit, cfgDirty, cfgStall;
   logic [31:0] xlateEa, cacheRdData, memAddr, memData, seenEa, seed;
   logic [31:4] cacheAddr;
   logic [1:0] cacheRdWord;
   dcm_pkg::dcm_issue_s issue;
   dcm_pkg::dcm_result_s result;
   int nXlate, nWrite, nBad, nInval, errorCnt, testsRun;

   dcm_block_maint i_dcm_block_maint (.clock(clock), .reset(reset),
      .issueValid(issueValid), .issueReady(issueReady), .issue(issue),
      .resultValid(resultValid), .result(result), .xerWrite(xerWrite),
      .xlateReq(xlateReq), .xlateEa(xlateEa), .xlateAsStore(xlateAsStore),
      .xlateDirect(xlateDirect), .xlateDenied(xlateDenied),
      .cacheLookup(cacheLookup), .cacheAddr(cacheAddr),
      .cacheHit(cacheHit), .cacheDirty(cacheDirty), .cacheRdEn(cacheRdEn),
      .cacheRdWord(cacheRdWord), .cacheRdData(cacheRdData),
      .cacheInval(cacheInval), .memValid(memValid), .memReady(memReady),
      .memAddr(memAddr), .memData(memData), .memLast(memLast));

   dcm_far_model i_dcm_far_model (.clock(clock), .clr(clr),
      .cfgDirect(cfgDirect), .cfgDenied(cfgDenied), .cfgHit(cfgHit),
      .cfgDirty(cfgDirty), .cfgStall(cfgStall), .xlateReq(xlateReq),
      .xlateEa(xlateEa), .xlateAsStore(xlateAsStore),
      .xlateDirect(xlateDirect), .xlateDenied(xlateDenied),
      .cacheLookup(cacheLookup), .cacheAddr(cacheAddr),
      .cacheHit(cacheHit), .cacheDirty(cacheDirty), .cacheRdEn(cacheRdEn),
      .cacheRdWord(cacheRdWord), .cacheRdData(cacheRdData),
      .cacheInval(cacheInval), .memValid(memValid), .memReady(memReady),
      .memAddr(memAddr), .memData(memData), .memLast(memLast),
      .seenEa(seenEa), .seenAsStore(seenAsStore), .nXlate(nXlate),
      .nWrite(nWrite), .nBad(nBad), .nInval(nInval));

   always #50 clock = ~clock;

   always @(posedge clock)
   begin
      if (xerWrite !== 1'b0)
         xerSeen <= 1'b1;
   end

   function automatic logic [31:0] nxt();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : nxt

   function automatic dcm_pkg::dcm_result_s want(input logic [1:0] op,
      input logic pv, input logic dr, input logic dn, input logic ht,
      input logic dt);
      dcm_pkg::dcm_result_s w;
      w = '0;
      if (op == 2'h3)
         w.illegal = 1'b1;
      else if (op == 2'h1 && !pv)
         w.privFault = 1'b1;
      else if (dr)
         w.noop = 1'b1;
      else if (dn)
         w.protFault = 1'b1;
      else
      begin
         w.wroteBack = ht & dt & (op != 2'h1);
         w.invalidated = ht & (op != 2'h2);
      end
      return w;
   endfunction : want

   task automatic endSim();
      $display("checks %0d mismatches %0d", testsRun, errorCnt);
      if (errorCnt == 0 && testsRun > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : endSim

   task automatic runOp(input int i);
      logic [31:0] r, base, idx, ins, ea;
      logic [1:0] op;
      logic [4:0] baseField;
      logic [9:0] xo;
      logic pv, dr, dn, ht, dt;
      dcm_pkg::dcm_result_s exp;
      int n;
      r = nxt();
      base = nxt();
      idx = nxt();
      op = (i < 6) ? i[1:0] : r[1:0];
      baseField = (i % 3 == 0) ? 5'h00 : r[6:2];
      pv = (i < 4) | ((i > 5) & r[7]);
      dr = (i == 4) | ((i >= 6) & (r[10:8] == 3'h0));
      dn = (i >= 6) & (r[13:11] == 3'h0);
      ht = (i < 4) | r[14];
      dt = (i < 4) | r[15];
      xo = op == 2'h0 ? dcm_pkg::XO_FLUSH : op == 2'h1 ? dcm_pkg::XO_INVAL :
           op == 2'h2 ? dcm_pkg::XO_STORE : 10'h116;
      ins = {dcm_pkg::PRI_CACHE, r[21:17], baseField, r[26:22], xo, r[27]};
      ea = (baseField == 5'h00 ? 32'h0 : base) + idx;
      exp = want(op, pv, dr, dn, ht, dt);
      @(posedge clock);
      clr <= 1'b1;
      cfgDirect <= dr;
      cfgDenied <= dn;
      cfgHit <= ht;
      cfgDirty <= dt;
      cfgStall <= r[16] | (i == 0);
      issueValid <= 1'b1;
      issue <= '{ins, base, idx, pv};
      @(negedge clock);
      `CHK("ready", 1'b1, issueReady)
      @(posedge clock);
      clr <= 1'b0;
      issueValid <= 1'b0;
      n = 0;
      do
      begin
         @(negedge clock);
         n++;
      end
      while (resultValid !== 1'b1 && n < 300);
      `CHK("done", 1'b1, resultValid)
      `CHK("busy", 1'b0, issueReady)
      `CHK("result", exp, result)
      `CHK("writes", (exp.wroteBack ? 4 : 0), nWrite)
      `CHK("inval", (exp.invalidated ? 1 : 0), nInval)
      `CHK("beats", 0, nBad)
      if (op != 2'h3)
      begin
         `CHK("xlate", 1, nXlate)
         `CHK("ea", ea, seenEa)
         `CHK("class", (op == 2'h1), seenAsStore)
      end
      `CHK("xer", 1'b0, xerSeen)
   endtask : runOp

   initial
   begin
      clock = 1'b0;
      reset = 1'b1;
      clr = 1'b1;
      issueValid = 1'b0;
      issue = '0;
      {cfgDirect, cfgDenied, cfgHit, cfgDirty, cfgStall} = 5'h00;
      xerSeen = 1'b0;
      seed = 32'h9bf6;
      errorCnt = 0;
      testsRun = 0;
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      for (int i = 0; i < 80; i++)
         runOp(i);
      endSim();
   end

   initial
   begin
      repeat (20000) @(posedge clock);
      errorCnt++;
      $display("MISMATCH watchdog expected 0 seen 1");
      endSim();
   end
endmodule : testbench
